// ===== core/sbda_defines.svh
// Constants of the data field and acknowledge logic: field kinds, control codes,
// status byte layout, byte limits and buffer sizes.
// Assumes inclusion by bare name from files under core/.
`ifndef SBDA_DEFINES_SVH
`define SBDA_DEFINES_SVH
// ======================================================================
// Field kinds reported by the bit layer
`define SBDA_KIND_MADDR 3'h0
`define SBDA_KIND_SADDR 3'h1
`define SBDA_KIND_CTRL 3'h2
`define SBDA_KIND_LEN 3'h3
`define SBDA_KIND_DATA 3'h4
// ======================================================================
// Control codes and the direction bit
`define SBDA_CTRL_DIR_BIT 3
`define SBDA_CTRL_STATUS 4'h0
`define SBDA_CTRL_RD_LOCK 4'h3
`define SBDA_CTRL_LKADR_LO 4'h4
`define SBDA_CTRL_LKADR_HI 4'h5
`define SBDA_CTRL_UNLOCK 4'h6
`define SBDA_CTRL_RD_DATA 4'h7
`define SBDA_CTRL_WR_LOCK_C 4'hA
`define SBDA_CTRL_WR_LOCK_D 4'hB
`define SBDA_CTRL_WR_C 4'hE
`define SBDA_CTRL_WR_D 4'hF
// ======================================================================
// Slave status byte layout
`define SBDA_ST_TXLOAD 0
`define SBDA_ST_RXHELD 1
`define SBDA_ST_LOCKED 2
`define SBDA_ST_TXRDY 4
`define SBDA_ST_MODE_HI 7
`define SBDA_ST_MODE_LO 6
`define SBDA_ST_MODE_VAL 2'h1
`define SBDA_ST_TXLOAD_RST 1'h1
`define SBDA_ST_RST 8'h41
// ======================================================================
// Per-frame byte limits by mode, and sizes
`define SBDA_MAX_M0 9'h010
`define SBDA_MAX_M1 9'h020
`define SBDA_MAX_M2 9'h080
`define SBDA_LEN_ZERO 9'h100
`define SBDA_DATA_W 8
`define SBDA_FIFO_DEPTH 8
`endif

// ===== core/sbda_pkg.sv
// Types shared by the data field and acknowledge logic.
// Assumes sbda_defines.svh is available for the constants.
`default_nettype none
package sbda_pkg;
  // ======================================================================
  // Frame sequencing states, one-hot
  typedef enum logic [2:0] {
    SBDA_IDLE = 3'h1,
    SBDA_HDR = 3'h2,
    SBDA_DATA = 3'h4
  } sbda_state_e;
  typedef logic [2:0] sbda_kind_t;
endpackage : sbda_pkg
`default_nettype wire

// ===== core/sbda_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sbda_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // ======================================================================
  // Handshakes; the head word sits in out_data, so a pop needs a stored word
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage array, written without reset to stay a plain memory
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered head word: loaded ahead so it holds the entry at the read pointer in the same cycle as out_valid
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_data <= '0;
    else if (pop)
      // A word pushed as the last one leaves is not yet in the array
      out_data <= (count == (AW+1)'(1) && push) ? in_data : mem[(rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1];
    else if (count == '0 || (count == (AW+1)'(1) && push == 1'b0))
      out_data <= push ? in_data : out_data;
    else
      out_data <= mem[rd_ptr];
  end
endmodule : sbda_fifo
`default_nettype wire

// ===== core/sbda_framer.sv
// Data field, parity and acknowledge logic of a multi-master serial bus unit.
// Assumes a bit layer on MCLK that reports each received field and each
// acknowledge bit as one-cycle strobes and sends the word offered on TX_*.
`timescale 1ns/1ps
`default_nettype none
`include "sbda_defines.svh"

// Function
// - Data word carries parity then acknowledge bit
// - Slave acks write only if even, empty
// - Unacknowledged transmitted word resent within limit
// - Acknowledged word advances to next word
// - Broadcast: no ack; failure stops reception
// - Master clocks read bits; slave supplies data
// - Reading master nacks odd or full; rereads
// - Reading master acks even, empty; reads next
// - No master read with broadcast addressing
// - Even parity on every field sent
// - Ack after slave address, control, length, data
// - Ack zero recognised, one not; broadcast ignored
// - Slave address nack on parity, timing, absence
// - Control nack on parity, enables, timing, undefined
// - Locked unit nacks foreign codes; lock reads
// - Status request acked unless parity or timing fails
// - Receive disable ignored for broadcast transfers
// - Length nack on parity or timing error
// - Data nack on parity, timing, full register
// - Individual resend after rejection; broadcast errors
// - Slave status byte shows last outcome
// - Status bits: loaded, held, locked, ready, mode
// - Control bit three selects transfer direction
module sbda_framer
  import sbda_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Frame setup and unit settings
  input wire logic FRAME_START,
  input wire logic IS_MASTER,
  input wire logic BCAST,
  input wire logic [1:0] MODE,
  input wire logic ADDR_MATCH,
  input wire logic LOCKED,
  input wire logic LOCK_OWNER,
  input wire logic SLAVE_RECEIVE_ENABLE,
  input wire logic SLAVE_TRANSMIT_ENABLE,
  input wire logic TIMING_ERR,
  // Received field from the bit layer
  input wire logic FIELD_STB,
  input wire logic [2:0] FIELD_KIND,
  input wire logic [11:0] FIELD_WORD,
  input wire logic FIELD_PAR,
  // Acknowledge bit seen on the bus
  input wire logic ACK_STB,
  input wire logic ACK_IN,
  // Acknowledge bit to drive
  output logic ACK_OUT_STB,
  output logic ACK_OUT,
  // Parity for header fields this unit sends
  input wire logic [11:0] HDR_WORD,
  input wire logic [2:0] HDR_KIND,
  output logic HDR_PAR,
  // Data word to send
  output logic TX_VALID,
  output logic [7:0] TX_WORD,
  output logic TX_PAR,
  // Transmit data from the processor
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  output logic WR_READY,
  // Data holding register toward the processor
  output logic [7:0] RD_DATA,
  output logic RD_FULL,
  input wire logic RD_TAKE,
  // Status and events
  output logic [7:0] SLAVE_STATUS,
  output logic FRAME_ACTIVE,
  output logic RX_ERROR,
  output logic DATA_REQUEST_INTERRUPT,
  output logic TRANSFER_END_INTERRUPT
);
  sbda_state_e state;
  logic is_master;
  logic bcast;
  logic write_dir;
  logic maddr_ok;
  logic len_seen;
  logic [8:0] len_left;
  logic [8:0] byte_cnt;
  logic [8:0] max_bytes;
  logic tx_have;
  logic tx_loaded;
  logic sending;
  logic acker;
  logic par_ok;
  logic ctrl_ok;
  logic good;
  logic data_fld;
  logic fin;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;

  // ======================================================================
  // Field parity and decisions
  // Even parity over the width that the field kind implies
  function automatic logic par_of(input logic [11:0] w, input logic [2:0] k);
    logic p;
    p = 1'b0;
    unique case (k)
      `SBDA_KIND_MADDR, `SBDA_KIND_SADDR: p = ^w;
      `SBDA_KIND_CTRL: p = ^w[3:0];
      default: p = ^w[7:0];
    endcase
    return p;
  endfunction : par_of

  // Control acceptance; a broadcast ignores the receive enable
  function automatic logic ctrl_accept(input logic [3:0] c, input logic bc, input logic rxe,
                                       input logic txe, input logic lk, input logic own);
    logic ok;
    ok = 1'b1;
    unique case (c)
      `SBDA_CTRL_STATUS: ok = 1'b1;
      `SBDA_CTRL_RD_LOCK, `SBDA_CTRL_RD_DATA: ok = txe & (!lk | own);
      `SBDA_CTRL_LKADR_LO, `SBDA_CTRL_LKADR_HI: ok = lk;
      `SBDA_CTRL_UNLOCK: ok = !lk | own;
      `SBDA_CTRL_WR_LOCK_C, `SBDA_CTRL_WR_LOCK_D, `SBDA_CTRL_WR_C, `SBDA_CTRL_WR_D:
        ok = (rxe | bc) & (!lk | own);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : ctrl_accept

  assign ctrl_ok = ctrl_accept(FIELD_WORD[3:0], bcast, SLAVE_RECEIVE_ENABLE, SLAVE_TRANSMIT_ENABLE,
                               LOCKED, LOCK_OWNER);
  assign par_ok = (par_of(FIELD_WORD, FIELD_KIND) == FIELD_PAR);
  assign sending = is_master ? write_dir : !write_dir;
  // receiver of each field but the master address returns its acknowledge
  assign acker = (FIELD_KIND == `SBDA_KIND_SADDR || FIELD_KIND == `SBDA_KIND_CTRL) ? !is_master : !sending;
  assign data_fld = FIELD_STB & (state == SBDA_DATA) & (FIELD_KIND == `SBDA_KIND_DATA) & !sending;

  // Acknowledge decision for the field on the strobe
  always_comb
  begin
    good = 1'b0;
    unique case (FIELD_KIND)
      `SBDA_KIND_SADDR: good = maddr_ok & par_ok & ADDR_MATCH & !TIMING_ERR;
      `SBDA_KIND_CTRL: good = par_ok & ctrl_ok & !TIMING_ERR;
      `SBDA_KIND_LEN: good = par_ok & !TIMING_ERR;
      `SBDA_KIND_DATA: good = par_ok & !RD_FULL & !TIMING_ERR;
      default: good = par_ok;
    endcase
  end

  always_comb
  begin
    unique case (MODE)
      2'h0: max_bytes = `SBDA_MAX_M0;
      2'h1: max_bytes = `SBDA_MAX_M1;
      default: max_bytes = `SBDA_MAX_M2;
    endcase
  end

  // Last attempt of the frame: all bytes done, the limit reached, or a broadcast word rejected
  always_comb
  begin
    fin = 1'b0;
    if (state == SBDA_DATA)
    begin
      if (data_fld)
        fin = ((len_left == 9'h001) & good) | (byte_cnt + 9'h001 >= max_bytes) | (bcast & !good);
      else if (ACK_STB & sending & tx_have)
        fin = ((len_left == 9'h001) & (!ACK_IN | bcast)) | (byte_cnt + 9'h001 >= max_bytes);
    end
  end

  // ======================================================================
  // Frame sequencing
  // Timing errors abort at once; header rejections end the frame
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state <= SBDA_IDLE;
    else if (FRAME_START)
      state <= SBDA_HDR;
    else if (TIMING_ERR || fin)
      state <= SBDA_IDLE;
    else if (state == SBDA_HDR && FIELD_STB && FIELD_KIND != `SBDA_KIND_MADDR && acker && !good)
      state <= SBDA_IDLE;
    else if (state == SBDA_HDR && FIELD_STB && FIELD_KIND == `SBDA_KIND_LEN && acker)
      state <= SBDA_DATA;
    // a one on the ack bit ends an individual frame
    else if (state == SBDA_HDR && ACK_STB && ACK_IN && !bcast)
      state <= SBDA_IDLE;
    else if (state == SBDA_HDR && ACK_STB && len_seen)
      state <= SBDA_DATA;
  end

  // Frame attributes, captured at start and from the header fields
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      is_master <= 1'b0;
      bcast <= 1'b0;
      write_dir <= 1'b1;
      maddr_ok <= 1'b0;
      len_seen <= 1'b0;
    end
    else if (FRAME_START)
    begin
      is_master <= IS_MASTER;
      bcast <= BCAST;
      write_dir <= 1'b1;
      maddr_ok <= 1'b0;
      len_seen <= 1'b0;
    end
    else if (FIELD_STB && state == SBDA_HDR)
    begin
      if (FIELD_KIND == `SBDA_KIND_MADDR)
        maddr_ok <= par_ok;
      // a broadcast always runs as a master write
      if (FIELD_KIND == `SBDA_KIND_CTRL)
        write_dir <= FIELD_WORD[`SBDA_CTRL_DIR_BIT] | bcast;
      if (FIELD_KIND == `SBDA_KIND_LEN)
        len_seen <= 1'b1;
    end
  end

  // Remaining bytes and attempted bytes; a length of zero means 256
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      len_left <= '0;
      byte_cnt <= '0;
    end
    else if (FRAME_START)
      byte_cnt <= '0;
    else if (FIELD_STB && state == SBDA_HDR && FIELD_KIND == `SBDA_KIND_LEN)
      len_left <= (FIELD_WORD[7:0] == 8'h00) ? `SBDA_LEN_ZERO : {1'b0, FIELD_WORD[7:0]};
    else if (data_fld)
    begin
      byte_cnt <= byte_cnt + 9'h001;
      if (good)
        len_left <= len_left - 9'h001;
    end
    else if (state == SBDA_DATA && ACK_STB && sending && tx_have)
    begin
      byte_cnt <= byte_cnt + 9'h001;
      if (!ACK_IN || bcast)
        len_left <= len_left - 9'h001;
    end
  end

  // ======================================================================
  // Acknowledge output
  // ack follows each received word and parity
  // broadcast receivers never drive the bit
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ACK_OUT_STB <= 1'b0;
      ACK_OUT <= 1'b1;
    end
    else
    begin
      ACK_OUT_STB <= FIELD_STB & (state != SBDA_IDLE) & acker & !bcast & (FIELD_KIND != `SBDA_KIND_MADDR);
      ACK_OUT <= !good;
    end
  end

  // ======================================================================
  // Transmit path
  // even parity for header fields this unit sends
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      HDR_PAR <= 1'b0;
    else
      HDR_PAR <= par_of(HDR_WORD, HDR_KIND);
  end

  // Transmit words queue here so the processor can run ahead of the bus
  sbda_fifo #(
    .WIDTH(`SBDA_DATA_W),
    .DEPTH(`SBDA_FIFO_DEPTH)
  ) u_txq (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_valid(WR_VALID),
    .in_data(WR_DATA),
    .in_ready(WR_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );
  // the sending unit, a writing master or a slave answering a read, takes its next word from the queue
  assign fifo_pop = fifo_valid & !tx_have & (state == SBDA_DATA) & sending;
  assign TX_VALID = tx_have;

  // Word on offer; a word left at frame end is dropped with the frame
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_have <= 1'b0;
      TX_WORD <= '0;
      TX_PAR <= 1'b0;
    end
    else if (fifo_pop)
    begin
      tx_have <= 1'b1;
      TX_WORD <= fifo_data;
      TX_PAR <= ^fifo_data;
    end
    else if (TIMING_ERR || fin || state == SBDA_IDLE)
      tx_have <= 1'b0;
    // a rejected word stays on offer for the resend
    else if (state == SBDA_DATA && ACK_STB && sending && (!ACK_IN || bcast))
      tx_have <= 1'b0;
  end

  // ======================================================================
  // Receive path
  // slave accepts only even parity into an empty register
  // reading master accepts into an empty register
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RD_FULL <= 1'b0;
      RD_DATA <= '0;
    end
    else if (data_fld && good)
    begin
      RD_FULL <= 1'b1;
      RD_DATA <= FIELD_WORD[7:0];
    end
    else if (RD_TAKE)
      RD_FULL <= 1'b0;
  end

  // Event pulses; a broadcast failure flags an error and stops reception
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      DATA_REQUEST_INTERRUPT <= 1'b0;
      TRANSFER_END_INTERRUPT <= 1'b0;
      RX_ERROR <= 1'b0;
    end
    else
    begin
      DATA_REQUEST_INTERRUPT <= data_fld & good;
      TRANSFER_END_INTERRUPT <= fin;
      // broadcast rejection is a reception error
      RX_ERROR <= data_fld & !good & bcast;
    end
  end

  // ======================================================================
  // Slave status
  // Loaded flag starts set; a finished slave transmit that drained the queue clears it
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      tx_loaded <= `SBDA_ST_TXLOAD_RST;
    else if (WR_VALID && WR_READY)
      tx_loaded <= 1'b1;
    else if (fin && sending && !is_master && !fifo_valid)
      tx_loaded <= 1'b0;
  end

  // fixed layout with reserved bits at zero
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      SLAVE_STATUS <= `SBDA_ST_RST;
    else
    begin
      SLAVE_STATUS <= '0;
      SLAVE_STATUS[`SBDA_ST_TXLOAD] <= tx_loaded;
      SLAVE_STATUS[`SBDA_ST_RXHELD] <= RD_FULL;
      SLAVE_STATUS[`SBDA_ST_LOCKED] <= LOCKED;
      SLAVE_STATUS[`SBDA_ST_TXRDY] <= SLAVE_TRANSMIT_ENABLE;
      SLAVE_STATUS[`SBDA_ST_MODE_HI:`SBDA_ST_MODE_LO] <= `SBDA_ST_MODE_VAL;
    end
  end

  assign FRAME_ACTIVE = (state != SBDA_IDLE);

  // ======================================================================
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_bad_word;
    data_fld && !bcast && !par_ok && !TIMING_ERR;
  endsequence
  sequence s_nack_out;
    ACK_OUT_STB && ACK_OUT && !DATA_REQUEST_INTERRUPT;
  endsequence

  rx_reject_nack_a: assert property (s_bad_word |=> s_nack_out)
    else $error("bad data word not rejected");
  rx_accept_ack_a: assert property (data_fld && good && !bcast |=> ACK_OUT_STB && !ACK_OUT && RD_FULL)
    else $error("good data word not accepted");
  bcast_silent_a: assert property (FIELD_STB && bcast && state != SBDA_IDLE |=> !ACK_OUT_STB)
    else $error("ack driven in broadcast");
  tx_resend_a: assert property (state == SBDA_DATA && sending && tx_have && ACK_STB && ACK_IN && !bcast
                                && !fin && !TIMING_ERR |=> tx_have && $stable(TX_WORD))
    else $error("rejected word not kept for resend");
  tx_parity_a: assert property (TX_VALID |-> TX_PAR == ^TX_WORD)
    else $error("transmit parity not even");
  status_ack_a: assert property (state == SBDA_HDR && FIELD_STB && FIELD_KIND == `SBDA_KIND_CTRL && !is_master
                                 && !bcast && par_ok && !TIMING_ERR && FIELD_WORD[3:0] == `SBDA_CTRL_STATUS
                                 |=> ACK_OUT_STB && !ACK_OUT)
    else $error("status request not acknowledged");
  byte_limit_a: assert property (state == SBDA_DATA |-> byte_cnt < max_bytes)
    else $error("byte limit exceeded");
  timing_abort_a: assert property (TIMING_ERR && !FRAME_START |=> state == SBDA_IDLE ##1 !TX_VALID)
    else $error("timing error did not end frame");
  status_layout_a: assert property (##1 SLAVE_STATUS[5] == 1'b0 && SLAVE_STATUS[3] == 1'b0
                                    && SLAVE_STATUS[7:6] == 2'h1 && SLAVE_STATUS[2] == $past(LOCKED))
    else $error("status byte layout wrong");
endmodule : sbda_framer
`default_nettype wire

// ===== tb/sbda_peer.sv
// Far-side bus unit: sends fields with parity, answers offered words.
// Assumes the bench calls its tasks; shares MCLK with the framer.
`timescale 1ns/1ps
`default_nettype none
module sbda_peer (
  // Clock
  input wire logic clk,
  // Field toward the framer
  output logic field_stb,
  output logic [2:0] field_kind,
  output logic [11:0] field_word,
  output logic field_par,
  // Acknowledge bit and offered word
  output logic ack_stb,
  output logic ack_in,
  input wire logic tx_valid,
  input wire logic [7:0] tx_word,
  input wire logic tx_par
);
  logic [8:0] last;
  // ==========
  // Field and acknowledge drivers
  initial
  begin
    {field_stb, field_kind, field_word, field_par, ack_stb, ack_in, last} = '0;
  end
  task automatic field(input logic [2:0] k, input logic [11:0] w, input logic bad);
    @(posedge clk);
    field_stb <= 1'b1;
    field_kind <= k;
    field_word <= w;
    field_par <= ^w ^ bad;
    @(posedge clk);
    field_stb <= 1'b0;
    // Released lines must not keep the old word
    field_word <= ~w;
    #1;
  endtask : field
  task automatic answer(input logic nack, input logic need);
    int n;
    n = 0;
    // Bounded wait so a stuck framer cannot hang the run
    while (need && tx_valid !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    last = {tx_par, tx_word};
    @(posedge clk);
    ack_stb <= 1'b1;
    ack_in <= nack;
    @(posedge clk);
    ack_stb <= 1'b0;
    ack_in <= ~nack;
    #1;
  endtask : answer
endmodule : sbda_peer
`default_nettype wire

// ===== tb/sbda_framer_tb.sv
// Bench: control acceptance, receive paths, broadcast errors, transmit retries.
// Assumes the design under core/ and the peer model under tb/.
`timescale 1ns/1ps
`default_nettype none
module sbda_framer_tb;
  logic MCLK, SYS_RST, FRAME_START, IS_MASTER, BCAST, ADDR_MATCH, LOCKED, LOCK_OWNER, TIMING_ERR;
  logic SLAVE_RECEIVE_ENABLE, SLAVE_TRANSMIT_ENABLE, FIELD_STB, FIELD_PAR, ACK_STB, ACK_IN, HDR_PAR;
  logic ACK_OUT_STB, ACK_OUT, TX_VALID, TX_PAR, WR_VALID, WR_READY, RD_FULL, RD_TAKE, FRAME_ACTIVE;
  logic RX_ERROR, DATA_REQUEST_INTERRUPT, TRANSFER_END_INTERRUPT;
  logic [1:0] MODE;
  logic [2:0] FIELD_KIND, HDR_KIND;
  logic [11:0] FIELD_WORD, HDR_WORD, w;
  logic [7:0] TX_WORD, WR_DATA, RD_DATA, SLAVE_STATUS, e;
  // Ack masks per control code: unlocked, locked by another unit, locked by this master
  logic [15:0] msk [3] = '{16'hCC41, 16'h0031, 16'hCCF9};
  int num_errors, checks, i, c, p;
  sbda_framer i_dut (.*);
  sbda_peer i_peer (.clk(MCLK), .field_stb(FIELD_STB), .field_kind(FIELD_KIND), .field_word(FIELD_WORD),
    .field_par(FIELD_PAR), .ack_stb(ACK_STB), .ack_in(ACK_IN), .tx_valid(TX_VALID), .tx_word(TX_WORD),
    .tx_par(TX_PAR));
  // ==========
  // Clock and tasks
  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  task automatic chk(input logic [11:0] s, input logic [11:0] x);
    checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic start(input logic m, input logic b);
    @(posedge MCLK);
    FRAME_START <= 1'b1;
    IS_MASTER <= m;
    BCAST <= b;
    @(posedge MCLK);
    FRAME_START <= 1'b0;
  endtask : start
  task automatic hdr(input logic [3:0] ctl, input logic [11:0] len);
    i_peer.field(3'h0, 12'h0A1, 1'b0);
    i_peer.field(3'h1, 12'h123, 1'b0);
    i_peer.field(3'h2, {8'h00, ctl}, 1'b0);
    i_peer.field(3'h3, len, 1'b0);
  endtask : hdr
  task automatic abort;
    @(posedge MCLK);
    TIMING_ERR <= 1'b1;
    @(posedge MCLK);
    TIMING_ERR <= 1'b0;
  endtask : abort
  task automatic take;
    @(posedge MCLK);
    RD_TAKE <= 1'b1;
    @(posedge MCLK);
    RD_TAKE <= 1'b0;
  endtask : take
  // ==========
  // Main sequence
  initial
  begin
    {FRAME_START, IS_MASTER, BCAST, LOCKED, LOCK_OWNER, TIMING_ERR, SLAVE_TRANSMIT_ENABLE} = '0;
    {WR_VALID, RD_TAKE, MODE, HDR_WORD, WR_DATA, w} = '0;
    {SYS_RST, SLAVE_RECEIVE_ENABLE, ADDR_MATCH, HDR_KIND} = 6'h39;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    #1;
    chk(SLAVE_STATUS, 8'h41);
    for (i = 0; i < 8; i++)
    begin
      w = w + 12'h2B7;
      @(posedge MCLK);
      HDR_WORD <= w;
      HDR_KIND <= i[2:0];
      @(posedge MCLK);
      #1;
      chk(HDR_PAR, (i < 2) ? ^w : (i == 2) ? ^w[3:0] : ^w[7:0]);
    end
    for (p = 0; p < 3; p++)
    begin
      @(posedge MCLK);
      LOCKED <= (p != 0);
      SLAVE_TRANSMIT_ENABLE <= (p != 0);
      LOCK_OWNER <= p[1];
      for (c = 0; c < 16; c++)
      begin
        start(1'b0, 1'b0);
        i_peer.field(3'h0, 12'h0A1, 1'b0);
        i_peer.field(3'h1, 12'h123, 1'b0);
        i_peer.field(3'h2, 12'(c), 1'b0);
        chk({ACK_OUT_STB, ACK_OUT}, {1'b1, !msk[p][c]});
        abort();
      end
    end
    #1;
    chk(SLAVE_STATUS, 8'h55);
    @(posedge MCLK);
    {LOCKED, SLAVE_TRANSMIT_ENABLE, LOCK_OWNER} <= 3'h0;
    start(1'b0, 1'b0);
    i_peer.field(3'h0, 12'h0A1, 1'b0);
    i_peer.field(3'h1, 12'h123, 1'b1);
    chk({ACK_OUT, FRAME_ACTIVE}, 2'b10);
    // No unit answers to this slave address
    start(1'b0, 1'b0);
    ADDR_MATCH <= 1'b0;
    i_peer.field(3'h0, 12'h0A1, 1'b0);
    i_peer.field(3'h1, 12'h123, 1'b0);
    chk({ACK_OUT, FRAME_ACTIVE}, 2'b10);
    start(1'b0, 1'b0);
    ADDR_MATCH <= 1'b1;
    hdr(4'hF, 12'h002);
    chk({ACK_OUT_STB, ACK_OUT}, 2'b10);
    i_peer.field(3'h4, 12'h0A5, 1'b0);
    chk({ACK_OUT_STB, ACK_OUT, RD_FULL, DATA_REQUEST_INTERRUPT, RD_DATA}, 12'hBA5);
    i_peer.field(3'h4, 12'h03C, 1'b0);
    chk(ACK_OUT, 1'b1);
    take();
    i_peer.field(3'h4, 12'h03C, 1'b1);
    chk(ACK_OUT, 1'b1);
    i_peer.field(3'h4, 12'h03C, 1'b0);
    chk({ACK_OUT, TRANSFER_END_INTERRUPT, FRAME_ACTIVE}, 3'b010);
    take();
    SLAVE_RECEIVE_ENABLE <= 1'b0;
    start(1'b0, 1'b1);
    hdr(4'hF, 12'h002);
    i_peer.field(3'h4, 12'h011, 1'b0);
    chk({ACK_OUT_STB, DATA_REQUEST_INTERRUPT, FRAME_ACTIVE}, 3'b011);
    i_peer.field(3'h4, 12'h022, 1'b0);
    chk({ACK_OUT_STB, RX_ERROR, FRAME_ACTIVE}, 3'b010);
    chk(SLAVE_STATUS[1], 1'b1);
    take();
    SLAVE_RECEIVE_ENABLE <= 1'b1;
    start(1'b1, 1'b0);
    hdr(4'h7, 12'h002);
    chk({ACK_OUT_STB, ACK_OUT}, 2'b10);
    i_peer.field(3'h4, 12'h0C3, 1'b0);
    chk({ACK_OUT, RD_DATA}, 9'h0C3);
    i_peer.field(3'h4, 12'h0C4, 1'b0);
    chk(ACK_OUT, 1'b1);
    abort();
    take();
    // Nine offers into eight places: the last must be refused
    for (i = 0; i < 9; i++)
    begin
      @(posedge MCLK);
      WR_VALID <= 1'b1;
      WR_DATA <= 8'h81 + i[7:0];
    end
    @(posedge MCLK);
    WR_VALID <= 1'b0;
    #1;
    chk(WR_READY, 1'b0);
    start(1'b1, 1'b0);
    hdr(4'hF, 12'h008);
    i_peer.answer(1'b0, 1'b0);
    e = 8'h81;
    for (i = 0; i < 9; i++)
    begin
      i_peer.answer(i == 0, 1'b1);
      chk(i_peer.last, {^e, e});
      if (i > 0)
        e++;
    end
    chk({FRAME_ACTIVE, WR_READY}, 2'b01);
    // Slave answering a master read; a drained queue clears the loaded bit
    @(posedge MCLK);
    WR_VALID <= 1'b1;
    WR_DATA <= 8'h3A;
    SLAVE_TRANSMIT_ENABLE <= 1'b1;
    @(posedge MCLK);
    WR_VALID <= 1'b0;
    start(1'b0, 1'b0);
    hdr(4'h7, 12'h001);
    i_peer.answer(1'b0, 1'b0);
    i_peer.answer(1'b0, 1'b1);
    chk(i_peer.last, 9'h03A);
    @(posedge MCLK);
    #1;
    chk({FRAME_ACTIVE, SLAVE_STATUS[0]}, 2'b00);
    // Retries end at the byte limit of each mode: 16, 32, then 128 attempts
    for (p = 0; p < 3; p++)
    begin
      @(posedge MCLK);
      WR_VALID <= 1'b1;
      WR_DATA <= 8'h5E;
      MODE <= p[1:0];
      @(posedge MCLK);
      WR_VALID <= 1'b0;
      start(1'b1, 1'b0);
      hdr(4'hF, 12'h001);
      i_peer.answer(1'b0, 1'b0);
      for (i = 0; i < ((p == 2) ? 128 : 16 << p); i++)
      begin
        chk(FRAME_ACTIVE, 1'b1);
        i_peer.answer(1'b1, 1'b1);
      end
      chk({FRAME_ACTIVE, i_peer.last}, 10'h15E);
    end
    report_and_stop();
  end
  // Whole run is under two thousand cycles; the cut-off at 10000 cycles lies well past that
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule : sbda_framer_tb
`default_nettype wire
